// ---- logic/gple_level_encoder.v ----
// Purpose: encode pin logic level as pulse-width pattern, plus registers
// Assumes: level input synchronous to clock_i
// Notes: read data valid one cycle after read strobe only
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "gple_defines.vh"
module gple_level_encoder
(
    input wire clock_i,
    input wire rst_i,
    input wire [7:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_write_i,
    input wire reg_read_i,
    output reg [15:0] reg_rdata_o,
    input wire pin_level_i,
    output reg pin_o,
    output reg pattern_phase_high_o
);
    reg [15:0] pin_low_level_pulse_config;
    reg [15:0] pin_high_level_pulse_config;
    reg [15:0] spare_scratch_section_one;
    reg [15:0] section_one_checksum_value;
    reg [6:0] high_count;
    reg [6:0] low_count;
    reg [6:0] phase_count;
    reg phase_high;
    reg next_pin;
    wire tick;
    wire [1:0] pulse_tick_select;
    wire [6:0] sel_high;
    wire [6:0] sel_low;

    ////////////////////////////////////////////////////////////////
    // register writes
    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pin_low_level_pulse_config <= `GPLE_RST_LOW_CFG;
            pin_high_level_pulse_config <= `GPLE_RST_HIGH_CFG;
            spare_scratch_section_one <= `GPLE_RST_SPARE;
            section_one_checksum_value <= `GPLE_RST_CHECKSUM;
        end
        else if (reg_write_i)
        begin
            if (reg_addr_i == `GPLE_ADDR_LOW_CFG)
                pin_low_level_pulse_config <= reg_wdata_i;
            else if (reg_addr_i == `GPLE_ADDR_HIGH_CFG)
                pin_high_level_pulse_config <= {2'h0, reg_wdata_i[13:0]};
            else if (reg_addr_i == `GPLE_ADDR_SPARE)
                spare_scratch_section_one <= reg_wdata_i;
            else if (reg_addr_i == `GPLE_ADDR_CHECKSUM)
                section_one_checksum_value <= reg_wdata_i;
        end
    end

    // read data, unmapped reads zero
    always @(posedge clock_i)
    begin
        if (rst_i)
            reg_rdata_o <= 16'h0000;
        else if (reg_read_i)
        begin
            if (reg_addr_i == `GPLE_ADDR_LOW_CFG)
                reg_rdata_o <= pin_low_level_pulse_config;
            else if (reg_addr_i == `GPLE_ADDR_HIGH_CFG)
                reg_rdata_o <= pin_high_level_pulse_config; // reserved bits held at 00
            else if (reg_addr_i == `GPLE_ADDR_SPARE)
                reg_rdata_o <= spare_scratch_section_one;
            else if (reg_addr_i == `GPLE_ADDR_CHECKSUM)
                reg_rdata_o <= section_one_checksum_value;
            else
                reg_rdata_o <= 16'h0000;
        end
        else
            reg_rdata_o <= 16'h0000;
    end

    ////////////////////////////////////////////////////////////////
    // tick source shared by both levels, rate set from the low config only
    assign pulse_tick_select = pin_low_level_pulse_config[`GPLE_TB_MSB:`GPLE_TB_LSB];

    gple_tick_divider u_tick
    (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .pulse_tick_select_i(pulse_tick_select),
        .tick_o(tick)
    );

    // pair for the level now at pin_level_i
    assign sel_high = pin_level_i ?
        pin_high_level_pulse_config[`GPLE_HC_MSB:`GPLE_HC_LSB] :
        pin_low_level_pulse_config[`GPLE_HC_MSB:`GPLE_HC_LSB];
    assign sel_low = pin_level_i ?
        pin_high_level_pulse_config[`GPLE_LC_MSB:`GPLE_LC_LSB] :
        pin_low_level_pulse_config[`GPLE_LC_MSB:`GPLE_LC_LSB];

    ////////////////////////////////////////////////////////////////
    // pattern sequencer, counts latched at each period start
    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            high_count <= 7'h00;
            low_count <= 7'h00;
            phase_count <= 7'h00;
            phase_high <= 1'b0;
        end
        else if (tick)
        begin
            if (phase_count != 7'h00)
                phase_count <= phase_count - 7'h01;
            else if (phase_high && (low_count != 7'h00))
            begin
                phase_high <= 1'b0;
                phase_count <= low_count - 7'h01;
            end
            else
            begin
                // period boundary: new counts take effect
                high_count <= sel_high;
                low_count <= sel_low;
                if (sel_high != 7'h00)
                begin
                    phase_high <= 1'b1;
                    phase_count <= sel_high - 7'h01;
                end
                else
                begin
                    phase_high <= 1'b0;
                    phase_count <= (sel_low == 7'h00) ? 7'h00 : sel_low - 7'h01;
                end
            end
        end
    end

    // static cases override pattern
    always @*
    begin
        if (high_count == 7'h00)
            next_pin = 1'b0;
        else if (low_count == 7'h00)
            next_pin = 1'b1;
        else
            next_pin = phase_high;
    end

    // registered pin drive
    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pin_o <= 1'b0;
            pattern_phase_high_o <= 1'b0;
        end
        else
        begin
            pin_o <= next_pin;
            pattern_phase_high_o <= phase_high;
        end
    end
endmodule

// ---- logic/gple_defines.vh ----
// Purpose: constants for the pin pulse-width level encoder
// Assumes: 8-bit register address, 16-bit register data
// Notes:
`ifndef GPLE_DEFINES_VH
`define GPLE_DEFINES_VH
`define GPLE_ADDR_LOW_CFG 8'h57
`define GPLE_ADDR_HIGH_CFG 8'h58
`define GPLE_ADDR_SPARE 8'h59
`define GPLE_ADDR_CHECKSUM 8'h7E
`define GPLE_RST_LOW_CFG 16'h007F
`define GPLE_RST_HIGH_CFG 16'h3F80
`define GPLE_RST_SPARE 16'h5555
`define GPLE_RST_CHECKSUM 16'h0000
`define GPLE_TB_MSB 15
`define GPLE_TB_LSB 14
`define GPLE_HC_MSB 13
`define GPLE_HC_LSB 7
`define GPLE_LC_MSB 6
`define GPLE_LC_LSB 0
`define GPLE_TICK_SEL0 10'h00F
`define GPLE_TICK_SEL1 10'h03F
`define GPLE_TICK_SEL2 10'h0FF
`define GPLE_TICK_SEL3 10'h3FF
`endif

// ---- logic/gple_tick_divider.v ----
// Purpose: one-cycle tick enable from selectable divider
// Assumes: selector changes are rare
// Notes: terminal value is divide ratio minus one
`timescale 1ns/10ps
`include "gple_defines.vh"
module gple_tick_divider
(
    input wire clock_i,
    input wire rst_i,
    input wire [1:0] pulse_tick_select_i,
    output reg tick_o
);
    reg [9:0] count;
    reg [9:0] terminal;

    // divide ratio lookup
    always @*
    begin
        case (pulse_tick_select_i)
            2'h0: terminal = `GPLE_TICK_SEL0;
            2'h1: terminal = `GPLE_TICK_SEL1;
            2'h2: terminal = `GPLE_TICK_SEL2;
            default: terminal = `GPLE_TICK_SEL3;
        endcase
    end

    // free-running counter, pulse on terminal
    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            count <= 10'h000;
            tick_o <= 1'b0;
        end
        else if (count >= terminal)
        begin
            count <= 10'h000;
            tick_o <= 1'b1;
        end
        else
        begin
            count <= count + 10'h001;
            tick_o <= 1'b0;
        end
    end
endmodule

// ---- testbench/gple_pulse_receiver.sv ----
// Purpose: far-side receiver timing pin pulses
// Assumes: pin sampled on clock_i
// Notes: done_o pulses at each rise
`timescale 1ns/10ps
module gple_pulse_receiver(
    input wire clock_i,
    input wire pin_i,
    output logic done_o,
    output logic [17:0] hi_o,
    output logic [17:0] lo_o
);
logic [17:0] run = 18'h0;
logic last = 1'b0;
////////////////
// time each run; a rise closes one period
always @(posedge clock_i)
begin
    done_o <= pin_i && !last;
    run <= pin_i != last ? 18'h1 : run + 18'h1;
    if (pin_i != last)
        {hi_o, lo_o} <= last ? {run, lo_o} : {hi_o, run};
    last <= pin_i;
end
endmodule

// ---- testbench/gple_sva.sv ----
// Purpose: encoder port checks
// Assumes: one clock domain
// Notes: bound from the bench
`timescale 1ns/10ps
module gple_sva(
    input wire clock_i,
    input wire rst_i,
    input wire [7:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_write_i,
    input wire reg_read_i,
    input wire [15:0] reg_rdata_o,
    input wire pin_level_i,
    input wire pin_o,
    input wire pattern_phase_high_o
);
default clocking @(posedge clock_i); endclocking
default disable iff (rst_i);
logic [15:0] lc, hc;
logic [17:0] run;
logic [1:0] nr;
logic lv;
wire w7 = reg_write_i && reg_addr_i == 8'h57;
wire w8 = reg_write_i && reg_addr_i == 8'h58;
wire [15:0] cf = pin_level_i ? hc : lc;
wire [17:0] tk = 18'h10 << {lc[15:14], 1'b0};
////////////////
// shadow pairs, run length, rises since a change
always @(posedge clock_i)
begin
    lv <= pin_level_i;
    run <= $changed(pin_o) ? 18'h1 : run + 18'h1;
    nr <= rst_i || w7 || w8 || pin_level_i != lv ? 2'h0 : nr + {1'h0, $rose(pin_o) && nr < 2'h3};
    lc <= rst_i ? 16'h007F : w7 ? reg_wdata_i : lc;
    hc <= rst_i ? 16'h3F80 : w8 ? reg_wdata_i : hc;
end
a_reset_idle: assert property ($fell(rst_i) |-> !pin_o && reg_rdata_o == 16'h0) else $error("idle");
a_spare_rw: assert property (reg_write_i && reg_addr_i == 8'h59 ##1 reg_read_i && reg_addr_i == 8'h59
    |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("spare");
a_cksum_rw: assert property (reg_write_i && reg_addr_i == 8'h7E ##1 reg_read_i && reg_addr_i == 8'h7E
    |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("checksum");
a_rsvd_zero: assert property (reg_read_i && reg_addr_i == 8'h58 |=> reg_rdata_o[15:14] == 2'h0)
    else $error("reserved");
a_static_low: assert property ($rose(pin_o) && nr > 2'h0 |-> cf[13:7] != 7'h0) else $error("low");
a_static_high: assert property ($fell(pin_o) && nr > 2'h0 |-> cf[6:0] != 7'h0) else $error("high");
a_high_len: assert property ($fell(pin_o) && nr > 2'h1 |-> run == cf[13:7] * tk) else $error("hi");
a_low_len: assert property ($rose(pin_o) && nr > 2'h1 |-> run == cf[6:0] * tk) else $error("lo");
a_phase_match: assert property (pin_o == pattern_phase_high_o) else $error("phase");
endmodule

// ---- testbench/gpio_pwm_level_encoder_tb.sv ----
// Purpose: bench for the level encoder
// Assumes: read data one cycle late
// Notes: one queue of expected results
`timescale 1ns/10ps
module gpio_pwm_level_encoder_tb;
logic clock_i = 0, rst_i = 1, reg_write_i = 0, reg_read_i = 0, pin_level_i = 0, rd = 0, pk = 0;
logic [7:0] reg_addr_i = 8'h00;
logic [15:0] reg_wdata_i = 16'h0000;
logic [31:0] lf = 32'h6198D97C;
logic [35:0] q[$];
wire [15:0] reg_rdata_o;
wire [17:0] hi, lo;
wire pin_o, pattern_phase_high_o, done;
int errors = 0, checks_done = 0;
gple_level_encoder i_gple_level_encoder(.*);
gple_pulse_receiver i_gple_pulse_receiver(.clock_i, .pin_i(pin_o), .done_o(done), .hi_o(hi), .lo_o(lo));
initial forever #2 clock_i = ~clock_i;
function [31:0] nx;
    nx = {lf[30:0], ^(lf & 32'h80200003)};
endfunction
task chk(input [35:0] e, s, input string n);
    checks_done++;
    if (e !== s)
    begin
        errors++;
        $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
endtask
task report_and_stop;
    if (errors == 0 && checks_done > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
task bus(input w, r, input [7:0] a, input [15:0] v);
    @(posedge clock_i);
    {reg_write_i, reg_read_i, reg_addr_i, reg_wdata_i} <= {w, r, a, v};
    if (r)
        q.push_back(v);
endtask
task pin(input l, input [15:0] v, input e, input [1:0] s);
    logic [17:0] t;
    lf = nx();
    t = 18'h10 << {s, 1'b0};
    pin_level_i <= l;
    bus(1, 0, l ? 8'h58 : 8'h57, v | (e ? 16'h0 : {s, 5'h0, lf[1:0], 5'h0, lf[3:2]} + 16'h81));
    bus(0, 0, 8'h00, 16'h0000);
    repeat (2) @(posedge done);
    q.push_back({(lf[1:0] + 18'h1) * t, (lf[3:2] + 18'h1) * t});
    @(posedge done);
endtask
// compare read data and receiver reports against the oldest note
always @(posedge clock_i)
    rd <= reg_read_i;
always @(negedge clock_i)
    if (rd || pk || done && q.size() > 0)
        chk(q.pop_front(), rd ? {20'h0, reg_rdata_o} : pk ? {35'h0, pin_o} : {hi, lo}, rd ? "rdata" : pk ? "static" : "pulse");
initial
begin
    repeat (12) @(posedge clock_i);
    rst_i <= 0;
    bus(0, 1, 8'h57, 16'h007F);
    bus(0, 1, 8'h58, 16'h3F80);
    bus(0, 1, 8'h59, 16'h5555);
    bus(0, 1, 8'h7E, 16'h0000);
    lf = nx();
    bus(1, 0, 8'h59, lf[15:0]);
    bus(0, 1, 8'h59, lf[15:0]);
    bus(1, 0, 8'h7E, ~lf[15:0]);
    bus(0, 1, 8'h7E, ~lf[15:0]);
    bus(1, 0, 8'h58, 16'hFFFF);
    bus(0, 1, 8'h58, 16'h3FFF);
    bus(0, 1, 8'h5A, 16'h0000);
    pin(1, 16'h0000, 0, 2'h0);
    for (int t = 0; t < 4; t++)
        pin(0, 16'h0000, 0, t[1:0]);
    // static high, then both counts zero gives static low
    bus(1, 0, 8'h57, 16'h0280);
    bus(0, 0, 8'h00, 16'h0000);
    repeat (600) @(posedge clock_i);
    q.push_back(36'h1);
    pk <= 1;
    @(posedge clock_i);
    pk <= 0;
    bus(1, 0, 8'h57, 16'h0000);
    bus(0, 0, 8'h00, 16'h0000);
    repeat (600) @(posedge clock_i);
    q.push_back(36'h0);
    pk <= 1;
    @(posedge clock_i);
    pk <= 0;
    @(posedge clock_i);
    report_and_stop;
end
initial
begin
    repeat (100000) @(posedge clock_i);
    errors++;
    report_and_stop;
end
endmodule
bind gple_level_encoder gple_sva i_gple_sva(.*);
